// ---- rsr_blank_timer.sv ----
`timescale 1ns/1ps
module rsr_blank_timer #(
   parameter int CYCLES = 200000
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic trigger_in,
   output logic blank_out
);
   logic [17:0] cnt_r;
   logic blank_r;

   // A new write restarts the full blanking window.
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cnt_r <= 18'h00000;
         blank_r <= 1'b0;
      end else if (trigger_in) begin
         cnt_r <= 18'(CYCLES - 1);
         blank_r <= 1'b1;
      end else if (cnt_r != 18'h00000) begin
         cnt_r <= cnt_r - 18'h00001;
      end else begin
         blank_r <= 1'b0;
      end
   end

   assign blank_out = blank_r;
endmodule

// ---- rsr_host_model.sv ----
`timescale 1ns/1ps
module rsr_host_model (
   input wire logic core_clk_in,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in,
   output rsr_pkg::rsr_reg_req_t req_out,
   output logic unlock_out
);
   initial begin
      req_out = '0;
      unlock_out = 1'b0;
   end
   // Callers also hand in reserved bits and may clear pulse skipping; the task writes whatever it is given.
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      req_out <= {1'b1, 1'b0, a, d};
      @(posedge core_clk_in);
      req_out <= '0;
      #1;
   endtask
   // A missing answer returns unknown so that the comparison fails.
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      req_out <= {1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk_in);
      req_out <= '0;
      #1;
      d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
   endtask
   task automatic set_unlock(input logic u);
      @(posedge core_clk_in);
      unlock_out <= u;
      #1;
   endtask
endmodule

// ---- rsr_params.svh ----
`ifndef RSR_PARAMS_SVH
`define RSR_PARAMS_SVH

`define RSR_ADDR_BUCK_BOOST 8'h19
`define RSR_ADDR_SLEW_CTRL 8'h1a
`define RSR_ADDR_LINEAR_REG 8'h1b

`define RSR_RST_BUCK_BOOST 8'h94
`define RSR_RST_SLEW_CTRL 8'h06
`define RSR_RST_LINEAR_REG 8'h1f
`define RSR_RST_BUCK_LEVEL 6'h00

`define RSR_BIT_PULSE_SKIP 7
`define RSR_BIT_START 7
`define RSR_BIT_IMMEDIATE 6
`define RSR_SLEW_CODE_MSB 2
`define RSR_CODE_MSB 5

`define RSR_SLEW_CODE_JUMP 3'h7
`define RSR_CLK_MHZ 40
`define RSR_BLANK_TIME_US 5000
`define RSR_BLANK_CYCLES (`RSR_BLANK_TIME_US * `RSR_CLK_MHZ)
`define RSR_STEP_BASE_TIME_US 160
`define RSR_STEP_BASE_CYCLES (`RSR_STEP_BASE_TIME_US * `RSR_CLK_MHZ)

`endif

// ---- rsr_pkg.sv ----
package rsr_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rsr_reg_req_t;

   typedef struct packed {
      logic pulse_skip_enable;
      logic [5:0] code;
   } rsr_bb_setting_t;

   typedef enum logic {
      RSR_IDLE,
      RSR_RAMP
   } rsr_step_state_t;

endpackage

// ---- rsr_setpoint_regs.sv ----
`timescale 1ns/1ps
`include "rsr_params.svh"
module rsr_setpoint_regs #(
   parameter int BLANK_CYCLES = `RSR_BLANK_CYCLES,
   parameter int STEP_BASE_CYCLES = `RSR_STEP_BASE_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire rsr_pkg::rsr_reg_req_t reg_req_in,
   input wire logic unlock_in,
   input wire logic [5:0] buck_rail_one_target_in,
   input wire logic [5:0] buck_rail_two_target_in,
   input wire logic [1:0] buck_setpoint_wr_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   output logic [5:0] buck_rail_one_level_out,
   output logic [5:0] buck_rail_two_level_out,
   output logic transition_busy_out,
   output rsr_pkg::rsr_bb_setting_t buck_boost_rail_out,
   output logic [5:0] linear_reg_rail_out,
   output logic buck_boost_blank_out,
   output logic linear_reg_blank_out
);

   // Register state.
   logic bb_pulse_skip_r;
   logic [5:0] bb_code_r;
   logic start_r;
   logic immediate_apply_r;
   logic [2:0] slew_code_r;
   logic [5:0] linear_code_r;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic busy_r;

   // Transition control state.
   logic launch_r;
   logic [12:0] step_cnt_r;
   logic [12:0] step_cnt_nxt;
   logic start_nxt;

   // Address decode.
   wire sel_bb = (reg_req_in.addr == `RSR_ADDR_BUCK_BOOST);
   wire sel_slew = (reg_req_in.addr == `RSR_ADDR_SLEW_CTRL);
   wire sel_linear = (reg_req_in.addr == `RSR_ADDR_LINEAR_REG);

   // Password-protected registers take a write only while unlocked.
   wire wr_bb = reg_req_in.wr && sel_bb && unlock_in;
   wire wr_slew = reg_req_in.wr && sel_slew;
   wire wr_linear = reg_req_in.wr && sel_linear && unlock_in;

   // Start requests.
   wire start_write = wr_slew && reg_req_in.wdata[`RSR_BIT_START];
   wire immediate_write = immediate_apply_r && (buck_setpoint_wr_in != 2'b00);
   // Without immediate-apply a setpoint write does not launch the steppers.
   wire launch_nxt = start_write || immediate_write;

   // Stepper status.
   wire one_busy;
   wire two_busy;
   wire any_busy = one_busy || two_busy;
   wire transition_done = start_r && !launch_r && !any_busy;

   // Step interval, halved per slew code.
   wire [12:0] step_limit = 13'(STEP_BASE_CYCLES >> slew_code_r);
   wire jump_mode = (slew_code_r == `RSR_SLEW_CODE_JUMP);
   wire step_tick = any_busy && !jump_mode && (step_cnt_r == step_limit - 13'h0001);

   // Read data mux; reserved bits are zero and unmapped addresses read zero.
   wire [7:0] rd_bb = {bb_pulse_skip_r, 1'b0, bb_code_r};
   wire [7:0] rd_slew = {start_r, immediate_apply_r, 3'b000, slew_code_r};
   wire [7:0] rd_linear = {2'b00, linear_code_r};
   wire [7:0] rd_mux = sel_bb ? rd_bb :
                       sel_slew ? rd_slew :
                       sel_linear ? rd_linear : 8'h00;

   // A write of 1 in the completion cycle keeps the bit set.
   assign start_nxt = start_write ? 1'b1 : (transition_done ? 1'b0 : start_r);

   // The step counter restarts at each launch so the first step takes a full interval.
   assign step_cnt_nxt = (launch_r || !any_busy || step_tick) ? 13'h0000 : step_cnt_r + 13'h0001;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         bb_pulse_skip_r <= 1'(`RSR_RST_BUCK_BOOST >> `RSR_BIT_PULSE_SKIP);
         bb_code_r <= 6'(`RSR_RST_BUCK_BOOST);
      end else if (wr_bb) begin
         bb_pulse_skip_r <= reg_req_in.wdata[`RSR_BIT_PULSE_SKIP];
         bb_code_r <= reg_req_in.wdata[`RSR_CODE_MSB:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         immediate_apply_r <= 1'(`RSR_RST_SLEW_CTRL >> `RSR_BIT_IMMEDIATE);
         slew_code_r <= 3'(`RSR_RST_SLEW_CTRL);
      end else if (wr_slew) begin
         immediate_apply_r <= reg_req_in.wdata[`RSR_BIT_IMMEDIATE];
         slew_code_r <= reg_req_in.wdata[`RSR_SLEW_CODE_MSB:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         linear_code_r <= 6'(`RSR_RST_LINEAR_REG);
      end else if (wr_linear) begin
         linear_code_r <= reg_req_in.wdata[`RSR_CODE_MSB:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         start_r <= 1'b0;
         launch_r <= 1'b0;
         step_cnt_r <= 13'h0000;
         busy_r <= 1'b0;
      end else begin
         start_r <= start_nxt;
         launch_r <= launch_nxt;
         step_cnt_r <= step_cnt_nxt;
         busy_r <= any_busy;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= reg_req_in.rd ? rd_mux : rdata_r;
         rvalid_r <= reg_req_in.rd;
      end
   end

   // Only the first two buck rails get steppers; other rails never see the slew logic.
   rsr_slew_stepper u_step_one (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .start_in(launch_r),
      .target_in(buck_rail_one_target_in),
      .step_in(step_tick),
      .jump_in(jump_mode),
      .level_out(buck_rail_one_level_out),
      .busy_out(one_busy)
   );

   rsr_slew_stepper u_step_two (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .start_in(launch_r),
      .target_in(buck_rail_two_target_in),
      .step_in(step_tick),
      .jump_in(jump_mode),
      .level_out(buck_rail_two_level_out),
      .busy_out(two_busy)
   );

   // Blanking starts on every accepted write, even one that leaves the code unchanged.
   rsr_blank_timer #(
      .CYCLES(BLANK_CYCLES)
   ) u_blank_bb (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .trigger_in(wr_bb),
      .blank_out(buck_boost_blank_out)
   );

   rsr_blank_timer #(
      .CYCLES(BLANK_CYCLES)
   ) u_blank_linear (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .trigger_in(wr_linear),
      .blank_out(linear_reg_blank_out)
   );

   assign reg_rdata_out = rdata_r;
   assign reg_rvalid_out = rvalid_r;
   assign transition_busy_out = busy_r;
   assign buck_boost_rail_out.pulse_skip_enable = bb_pulse_skip_r;
   assign buck_boost_rail_out.code = bb_code_r;
   assign linear_reg_rail_out = linear_code_r;
endmodule

// ---- rsr_setpoint_regs_asserts.sv ----
`timescale 1ns/1ps
`include "rsr_params.svh"
module rsr_setpoint_regs_asserts (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire rsr_pkg::rsr_reg_req_t reg_req_in,
   input wire logic unlock_in,
   input wire logic [5:0] buck_rail_one_target_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic [5:0] buck_rail_one_level_out,
   input wire logic transition_busy_out,
   input wire rsr_pkg::rsr_bb_setting_t buck_boost_rail_out,
   input wire logic [5:0] linear_reg_rail_out,
   input wire logic buck_boost_blank_out,
   input wire logic linear_reg_blank_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   wire wr_lin = reg_req_in.wr && reg_req_in.addr == `RSR_ADDR_LINEAR_REG;
   wire wr_bb = reg_req_in.wr && reg_req_in.addr == `RSR_ADDR_BUCK_BOOST;
   wire wr_slew = reg_req_in.wr && reg_req_in.addr == `RSR_ADDR_SLEW_CTRL;
   wire rd_slew = reg_req_in.rd && reg_req_in.addr == `RSR_ADDR_SLEW_CTRL;
   wire [5:0] wcode = reg_req_in.wdata[5:0];
   // Only the first eight blanking cycles are held here; the full span is timed by the bench.
   sequence blank_hold_s(b);
      b [*8];
   endsequence
   chk_read_answer: assert property (reg_req_in.rd |=> reg_rvalid_out)
      else $error("read not answered");
   chk_slew_reserved: assert property (rd_slew |=> reg_rdata_out[5:3] == 3'h0)
      else $error("slew reserved bits set");
   chk_lin_locked: assert property (wr_lin && !unlock_in |=> $stable(linear_reg_rail_out))
      else $error("locked linear write took effect");
   chk_bb_locked: assert property (wr_bb && !unlock_in |=> $stable(buck_boost_rail_out))
      else $error("locked buck-boost write took effect");
   chk_lin_write: assert property (wr_lin && unlock_in |=> linear_reg_rail_out == $past(wcode))
      else $error("linear setpoint not stored");
   chk_lin_blank: assert property (wr_lin && unlock_in |=> blank_hold_s(linear_reg_blank_out))
      else $error("linear monitor not blanked");
   chk_bb_blank: assert property (wr_bb && unlock_in |=> blank_hold_s(buck_boost_blank_out))
      else $error("buck-boost monitor not blanked");
   chk_slew_scope: assert property (wr_slew |=> $stable(buck_boost_rail_out) && $stable(linear_reg_rail_out))
      else $error("slew write moved another rail");
   chk_level_busy: assert property ($changed(buck_rail_one_level_out) |-> ##[0:1] transition_busy_out)
      else $error("level moved without transition");
   chk_busy_done: assert property ($fell(transition_busy_out) |-> buck_rail_one_level_out == buck_rail_one_target_in)
      else $error("transition ended off target");
endmodule
bind rsr_setpoint_regs rsr_setpoint_regs_asserts i_rsr_setpoint_regs_asserts (.core_clk_in, .reset_in,
   .reg_req_in, .unlock_in, .buck_rail_one_target_in, .reg_rdata_out, .reg_rvalid_out, .buck_rail_one_level_out,
   .transition_busy_out, .buck_boost_rail_out, .linear_reg_rail_out, .buck_boost_blank_out, .linear_reg_blank_out);

// ---- rsr_setpoint_regs_tb.sv ----
`timescale 1ns/1ps
`include "rsr_params.svh"
module rsr_setpoint_regs_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   rsr_pkg::rsr_reg_req_t req;
   rsr_pkg::rsr_bb_setting_t bb;
   logic unlock, rvalid, busy, bbb, lb;
   logic [5:0] t1 = 6'h00, t2 = 6'h00, l1, l2, lin;
   logic [1:0] swr = 2'b00;
   logic [7:0] rdata, v;
   int n_fail = 0, total_checks = 0, g, c;
   always #12.5 clk = ~clk;
   rsr_setpoint_regs #(.BLANK_CYCLES(20), .STEP_BASE_CYCLES(64)) i_rsr_setpoint_regs (.core_clk_in(clk),
      .reset_in(rst), .reg_req_in(req), .unlock_in(unlock), .buck_rail_one_target_in(t1),
      .buck_rail_two_target_in(t2), .buck_setpoint_wr_in(swr), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .buck_rail_one_level_out(l1), .buck_rail_two_level_out(l2), .transition_busy_out(busy),
      .buck_boost_rail_out(bb), .linear_reg_rail_out(lin), .buck_boost_blank_out(bbb), .linear_reg_blank_out(lb));
   rsr_host_model i_rsr_host_model (.core_clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req),
      .unlock_out(unlock));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
      i_rsr_host_model.read(a, v);
      check(what, v, e);
   endtask
   task automatic wait_idle;
      int k;
      repeat (4) @(posedge clk);
      for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
      #1;
   endtask
   // Counts edges between two level moves of rail one.
   task automatic step_gap(output int n);
      logic [5:0] p;
      p = l1;
      for (n = 0; n < 3000 && l1 === p; n++) @(posedge clk) #1;
      p = l1;
      for (n = 0; n < 3000 && l1 === p; n++) @(posedge clk) #1;
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      n_fail++;
      end_of_test;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd_chk(`RSR_ADDR_SLEW_CTRL, `RSR_RST_SLEW_CTRL, "slew");
      rd_chk(`RSR_ADDR_BUCK_BOOST, 8'h94, "bb");
      rd_chk(`RSR_ADDR_LINEAR_REG, 8'h1f, "lin");
      rd_chk(8'h30, 8'h00, "unmapped");
      i_rsr_host_model.write(`RSR_ADDR_SLEW_CTRL, 8'h7f);
      rd_chk(`RSR_ADDR_SLEW_CTRL, 8'h47, "slew rsv");
      i_rsr_host_model.write(`RSR_ADDR_LINEAR_REG, 8'h05);
      check("lin blank", {7'h0, lb}, 8'h00);
      rd_chk(`RSR_ADDR_LINEAR_REG, 8'h1f, "lin lock");
      i_rsr_host_model.set_unlock(1'b1);
      i_rsr_host_model.write(`RSR_ADDR_LINEAR_REG, 8'hff);
      check("lin blank", {7'h0, lb}, 8'h01);
      check("lin out", {2'h0, lin}, 8'h3f);
      rd_chk(`RSR_ADDR_LINEAR_REG, 8'h3f, "lin");
      repeat (22) @(posedge clk) #1;
      check("lin blank end", {7'h0, lb}, 8'h00);
      i_rsr_host_model.write(`RSR_ADDR_BUCK_BOOST, 8'h45);
      check("bb out", {1'b0, bb}, 8'h05);
      check("bb blank", {7'h0, bbb}, 8'h01);
      rd_chk(`RSR_ADDR_BUCK_BOOST, 8'h05, "bb");
      i_rsr_host_model.write(`RSR_ADDR_SLEW_CTRL, 8'h06);
      @(posedge clk);
      t1 <= 6'h0a;
      t2 <= 6'h03;
      swr <= 2'b11;
      @(posedge clk);
      swr <= 2'b00;
      repeat (20) @(posedge clk) #1;
      check("held", {2'h0, l1}, 8'h00);
      check("held two", {2'h0, l2}, 8'h00);
      i_rsr_host_model.write(`RSR_ADDR_SLEW_CTRL, 8'h86);
      wait_idle;
      check("l1", {2'h0, l1}, 8'h0a);
      check("l2", {2'h0, l2}, 8'h03);
      rd_chk(`RSR_ADDR_SLEW_CTRL, 8'h06, "start clr");
      for (c = 0; c < 7; c++) begin
         @(posedge clk);
         t1 <= (c % 2 == 1) ? 6'h0a : 6'h10;
         i_rsr_host_model.write(`RSR_ADDR_SLEW_CTRL, 8'h80 | 8'(c));
         step_gap(g);
         check("step time", 8'(g), 8'(64 >> c));
         check("busy", {7'h0, busy}, 8'h01);
         wait_idle;
      end
      @(posedge clk);
      t1 <= 6'h30;
      i_rsr_host_model.write(`RSR_ADDR_SLEW_CTRL, 8'h87);
      repeat (3) @(posedge clk) #1;
      check("jump", {2'h0, l1}, 8'h30);
      wait_idle;
      i_rsr_host_model.write(`RSR_ADDR_SLEW_CTRL, 8'h46);
      @(posedge clk);
      t1 <= 6'h12;
      t2 <= 6'h08;
      swr <= 2'b11;
      @(posedge clk);
      swr <= 2'b00;
      wait_idle;
      check("imm l1", {2'h0, l1}, 8'h12);
      check("imm l2", {2'h0, l2}, 8'h08);
      i_rsr_host_model.set_unlock(1'b0);
      i_rsr_host_model.write(`RSR_ADDR_BUCK_BOOST, 8'h94);
      check("bb lock", {1'b0, bb}, 8'h05);
      check("bb blank end", {7'h0, bbb}, 8'h00);
      rd_chk(`RSR_ADDR_BUCK_BOOST, 8'h05, "bb lock");
      end_of_test;
   end
endmodule

// ---- rsr_slew_stepper.sv ----
`timescale 1ns/1ps
`include "rsr_params.svh"
module rsr_slew_stepper (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic start_in,
   input wire logic [5:0] target_in,
   input wire logic step_in,
   input wire logic jump_in,
   output logic [5:0] level_out,
   output logic busy_out
);
   rsr_pkg::rsr_step_state_t state_r;
   rsr_pkg::rsr_step_state_t state_nxt;
   logic [5:0] level_r;
   logic [5:0] level_nxt;
   logic [5:0] tgt_r;
   logic [5:0] tgt_nxt;

   assign tgt_nxt = start_in ? target_in : tgt_r;

   // One code per step interval (jump mode moves straight to target); the slew code sets the step time and so the rate.
   always_comb begin
      level_nxt = level_r;
      state_nxt = state_r;
      case (state_r)
         rsr_pkg::RSR_IDLE: begin
            if (start_in) begin
               state_nxt = rsr_pkg::RSR_RAMP;
            end
         end
         rsr_pkg::RSR_RAMP: begin
            if (jump_in) begin
               level_nxt = tgt_r;
            end else if (step_in && level_r < tgt_r) begin
               level_nxt = level_r + 6'h01;
            end else if (step_in && level_r > tgt_r) begin
               level_nxt = level_r - 6'h01;
            end
            if (!start_in && level_nxt == tgt_r) begin
               state_nxt = rsr_pkg::RSR_IDLE;
            end
         end
         default: begin
            state_nxt = rsr_pkg::RSR_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         state_r <= rsr_pkg::RSR_IDLE;
         level_r <= `RSR_RST_BUCK_LEVEL;
         tgt_r <= `RSR_RST_BUCK_LEVEL;
      end else begin
         state_r <= state_nxt;
         level_r <= level_nxt;
         tgt_r <= tgt_nxt;
      end
   end

   assign level_out = level_r;
   assign busy_out = (state_r == rsr_pkg::RSR_RAMP);
endmodule
